// *** rivp_core_model.sv ***
// Purpose: Behavioural core fetch side facing the vector block
// Assumes: One instruction retires every other cycle
// Notes:   Accepts only while pending is shown, then waits out the answer
`timescale 1ns/1ps
`default_nettype none

module rivp_core_model
  import rivp_pkg::*;
(
  input  wire logic                    clock_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    irq_pending_in,
  input  wire logic                    vector_valid_in,
  input  wire logic [rivp_pkg::AW-1:0] vector_addr_in,
  input  wire logic                    ie_cmd_in,
  input  wire logic                    slow_in,
  output logic                         core_accept_out,
  output logic                         instr_done_out,
  output logic                         global_ie_out,
  output logic      [rivp_pkg::AW-1:0] fetch_addr_out,
  output logic      [7:0]              fetch_count_out
);
  logic [2:0] wait_q;

  // ****************************************************************
  // Accept and fetch
  // ****************************************************************
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      core_accept_out <= 1'b0;
      instr_done_out  <= 1'b0;
      global_ie_out   <= 1'b0;
      fetch_addr_out  <= 16'h0000;
      fetch_count_out <= 8'h00;
      wait_q          <= 3'h0;
    end
    else
    begin
      instr_done_out  <= ~instr_done_out;
      global_ie_out   <= ie_cmd_in;
      core_accept_out <= 1'b0;
      if (vector_valid_in)
      begin
        fetch_addr_out  <= vector_addr_in;
        fetch_count_out <= fetch_count_out + 8'h01;
      end
      // Slow mode waits six cycles after an accept instead of two before the next one
      if (wait_q != 3'h0)
        wait_q <= wait_q - 3'h1;
      else if (irq_pending_in)
      begin
        core_accept_out <= 1'b1;
        wait_q          <= slow_in ? 3'h6 : 3'h2;
      end
    end
  end
endmodule

`default_nettype wire

// *** rivp_pkg.sv ***
// Purpose: Shared constants for the reset and interrupt vector placement block
// Assumes: Word addressed program memory, 16-bit vector addresses
// Notes:   Register offsets are byte addresses of 32-bit words
`default_nettype none

package rivp_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_IRQ = 21;
  localparam int IDX_W   = 5;
  localparam int AW      = 16;
  localparam int DW      = 32;
  localparam int RAW     = 8;
  localparam int EVT_W   = 3;

  // ****************************************************************
  // Vector placement
  // ****************************************************************
  localparam logic [AW-1:0] APP_RESET_ADDR  = 16'h0000;
  localparam logic [AW-1:0] APP_TABLE_BASE  = 16'h0000;
  localparam logic [AW-1:0] BOOT_START_ADDR = 16'h1C00;
  localparam logic [AW-1:0] VEC_STRIDE      = 16'h0002;
  localparam logic          FUSE_PROGRAMMED = 1'b0;
  localparam logic [IDX_W-1:0] FIRST_IRQ_VEC_NUM = 5'h02;

  // ****************************************************************
  // Vector change unlock window, in clock cycles
  // ****************************************************************
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

  // ****************************************************************
  // Registers
  // ****************************************************************
  localparam logic [RAW-1:0] REG_MCU_CTRL = 8'h00;
  localparam logic [RAW-1:0] REG_INT_STAT = 8'h04;
  localparam logic [RAW-1:0] REG_INT_MASK = 8'h08;
  localparam logic [RAW-1:0] REG_VEC_STAT = 8'h0C;

  localparam int CTRL_UNLOCK_BIT = 0;
  localparam int CTRL_SELECT_BIT = 1;

  localparam int EVT_TABLE_MOVED    = 0;
  localparam int EVT_UNLOCK_EXPIRED = 1;
  localparam int EVT_VECTOR_TAKEN   = 2;

  localparam int VSTAT_NUM_LSB   = 0;
  localparam int VSTAT_FUSE_BIT  = 8;
  localparam int VSTAT_BLOCK_BIT = 9;

endpackage

`default_nettype wire

// *** rivp_prio_enc.sv ***
// Purpose: Lowest-index selection among pending interrupt requests
// Assumes: Requests are already gated by their peripheral enables
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none

module rivp_prio_enc
  import rivp_pkg::*;
(
  input  wire logic [rivp_pkg::NUM_IRQ-1:0] req_in,
  output logic                              any_out,
  output logic [rivp_pkg::IDX_W-1:0]        idx_out
);

  // ****************************************************************
  // Scan from the top so the lowest index wins
  // ****************************************************************
  always_comb
  begin
    any_out = 1'b0;
    idx_out = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
    begin
      if (req_in[i])
      begin
        any_out = 1'b1;
        idx_out = IDX_W'(i);
      end
    end
  end

endmodule

`default_nettype wire

// *** rivp_unlock_guard.sv ***
// Purpose: Vector change unlock window and interrupt blocking
// Assumes: Select writes are flagged by the caller only while unlocked
// Notes:   Block also covers the cycle in which the unlock is set
`timescale 1ns/1ps
`default_nettype none

module rivp_unlock_guard
  import rivp_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic set_unlock_in,
  input  wire logic select_write_in,
  input  wire logic instr_done_in,
  output logic      unlock_out,
  output logic      block_out,
  output logic      expired_out
);

  logic [2:0] cnt_q;
  logic       unlock_q;
  logic       wait_instr_q;

  assign unlock_out  = unlock_q;
  assign expired_out = unlock_q && !set_unlock_in && !select_write_in && (cnt_q == 3'h1);
  assign block_out   = set_unlock_in || unlock_q || wait_instr_q;

  // ****************************************************************
  // Unlock window
  // ****************************************************************
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      unlock_q <= 1'b0;
      cnt_q    <= '0;
    end
    else if (set_unlock_in)
    begin
      unlock_q <= 1'b1;
      cnt_q    <= UNLOCK_CYCLES;
    end
    else if (select_write_in || expired_out)
    begin
      unlock_q <= 1'b0;
      cnt_q    <= '0;
    end
    else if (unlock_q)
    begin
      cnt_q <= cnt_q - 3'h1;
    end
  end

  // ****************************************************************
  // Hold the block until the instruction after the select write ends
  // ****************************************************************
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      wait_instr_q <= 1'b0;
    else if (select_write_in)
      wait_instr_q <= 1'b1;
    else if (instr_done_in)
      wait_instr_q <= 1'b0;
  end

endmodule

`default_nettype wire

// *** rivp_vector_ctrl.sv ***
// Purpose: Reset and interrupt vector address generation with table relocation
// Assumes: Inputs synchronous to clock_in; boot section fixed at 2K bytes
// Notes:   Boot fuse is sampled once, in the first cycle after reset release
//
// Operation
// RULE1 - Every reset source goes to vector one, address 0x0000 with fuse unprogrammed.
// RULE2 - External request zero vector sits at table offset 0x0002, vector two.
// RULE3 - Pin change group zero at offset 0x0004, group one at 0x0006.
// RULE4 - Timer two, timer one and timer zero vectors at offsets 0x0008 to 0x0016.
// RULE5 - Serial vectors at offsets 0x0018 through 0x0022.
// RULE6 - Comparator, converter, eeprom and self-program vectors at 0x0024 to 0x002A.
// RULE7 - Programmed fuse starts at boot reset address, unprogrammed at 0x0000.
// RULE8 - With select set, vector address is table offset plus boot start.
// RULE9 - Table base follows select only; reset address follows the fuse only.
// RULE10 - A vector is fetched only when its interrupt is actually taken.
// RULE11 - Boot start 0x1C00; relocated vectors span 0x1C02 to 0x1C2A.
// RULE12 - Unlock then select write within four cycles; unlock self-clears.
// RULE13 - Interrupts blocked from unlock until after the next instruction, else four cycles.
// RULE14 - Among pending requests the lowest vector number is chosen.
// RULE15 - Consecutive vectors are two words apart.
`timescale 1ns/1ps
`default_nettype none

module rivp_vector_ctrl
  import rivp_pkg::*;
(
  input  wire logic                         clock_in,
  input  wire logic                         rst_n_in,
  input  wire logic [rivp_pkg::RAW-1:0]     reg_addr_in,
  input  wire logic [rivp_pkg::DW-1:0]      reg_wdata_in,
  input  wire logic                         reg_we_in,
  input  wire logic                         reg_re_in,
  output logic      [rivp_pkg::DW-1:0]      reg_rdata_out,
  input  wire logic                         boot_reset_select_fuse_in,
  input  wire logic [rivp_pkg::NUM_IRQ-1:0] irq_req_in,
  input  wire logic                         global_ie_in,
  input  wire logic                         core_accept_in,
  input  wire logic                         instr_done_in,
  output logic      [rivp_pkg::AW-1:0]      reset_vector_out,
  output logic                              irq_pending_out,
  output logic      [rivp_pkg::AW-1:0]      vector_addr_out,
  output logic                              vector_valid_out,
  output logic                              vector_table_select_out,
  output logic                              irq_out
);

  // ****************************************************************
  // Vector table, offsets from the table base
  // ****************************************************************
  localparam logic [AW-1:0] VEC_OFS [NUM_IRQ] = '{ // [RULE15]
    16'h0002,                                     // [RULE2]
    16'h0004, 16'h0006,                           // [RULE3]
    16'h0008, 16'h000A, 16'h000C, 16'h000E,       // [RULE4]
    16'h0010, 16'h0012, 16'h0014, 16'h0016,       // [RULE4]
    16'h0018, 16'h001A, 16'h001C, 16'h001E,       // [RULE5]
    16'h0020, 16'h0022,                           // [RULE5]
    16'h0024, 16'h0026, 16'h0028, 16'h002A        // [RULE6]
  };

  function automatic logic hit(input logic [RAW-1:0] addr, input logic [RAW-1:0] ofs);
    hit = (addr == ofs);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  logic                 fuse_q;
  logic                 fuse_cap_q;
  logic                 select_q;
  logic [AW-1:0]        reset_vec_q;
  logic                 pending_q;
  logic [AW-1:0]        vec_addr_q;
  logic                 vec_valid_q;
  logic [IDX_W-1:0]     last_num_q;
  logic [EVT_W-1:0]     stat_q;
  logic [EVT_W-1:0]     mask_q;
  logic                 irq_q;
  logic [DW-1:0]        rdata_q;

  logic                 set_unlock;
  logic                 select_write;
  logic                 unlock;
  logic                 block;
  logic                 expired;
  logic                 any_req;
  logic [IDX_W-1:0]     win_idx;
  logic                 take;
  logic [AW-1:0]        table_base;
  logic [EVT_W-1:0]     evt;
  logic [EVT_W-1:0]     stat_d;
  logic                 ctrl_wr;

  assign reg_rdata_out           = rdata_q;
  assign reset_vector_out        = reset_vec_q;
  assign irq_pending_out         = pending_q;
  assign vector_addr_out         = vec_addr_q;
  assign vector_valid_out        = vec_valid_q;
  assign vector_table_select_out = select_q;
  assign irq_out                 = irq_q;

  // ****************************************************************
  // Boot fuse capture and reset vector
  // ****************************************************************
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      fuse_q     <= 1'b1;
      fuse_cap_q <= 1'b0;
    end
    else if (!fuse_cap_q)
    begin
      fuse_q     <= boot_reset_select_fuse_in;
      fuse_cap_q <= 1'b1;
    end
  end

  // Reset address ignores the select bit by design
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      reset_vec_q <= APP_RESET_ADDR;                                        // [RULE1]
    else if (fuse_q == FUSE_PROGRAMMED)
      reset_vec_q <= BOOT_START_ADDR;                                       // [RULE7] [RULE9]
    else
      reset_vec_q <= APP_RESET_ADDR;                                        // [RULE1] [RULE7]
  end

  // ****************************************************************
  // Control register writes and unlock sequence
  // ****************************************************************
  assign ctrl_wr      = reg_we_in && hit(reg_addr_in, REG_MCU_CTRL);
  assign set_unlock   = ctrl_wr && reg_wdata_in[CTRL_UNLOCK_BIT];               // [RULE12]
  // A select write without a live unlock is dropped
  assign select_write = ctrl_wr && !reg_wdata_in[CTRL_UNLOCK_BIT] && unlock;    // [RULE12]

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      select_q <= 1'b0;
    else if (select_write)
      select_q <= reg_wdata_in[CTRL_SELECT_BIT];                            // [RULE12]
  end

  rivp_unlock_guard u_guard (
    .clock_in        (clock_in),
    .rst_n_in        (rst_n_in),
    .set_unlock_in   (set_unlock),
    .select_write_in (select_write),
    .instr_done_in   (instr_done_in),
    .unlock_out      (unlock),
    .block_out       (block),
    .expired_out     (expired)
  );

  // ****************************************************************
  // Request selection and vector formation
  // ****************************************************************
  rivp_prio_enc u_prio (
    .req_in  (irq_req_in),
    .any_out (any_req),
    .idx_out (win_idx)
  );

  // Base depends on select only, never on the fuse
  assign table_base = select_q ? BOOT_START_ADDR : APP_TABLE_BASE;          // [RULE8] [RULE9] [RULE11]
  // Global flag is left alone; blocking only masks pending and acceptance
  assign take = core_accept_in && any_req && global_ie_in && !block;        // [RULE10] [RULE13]

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      pending_q <= 1'b0;
    else
      pending_q <= any_req && global_ie_in && !block;                       // [RULE13]
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      vec_addr_q  <= APP_TABLE_BASE;
      vec_valid_q <= 1'b0;
      last_num_q  <= '0;
    end
    else
    begin
      vec_valid_q <= take;                                                  // [RULE10]
      if (take)
      begin
        vec_addr_q <= table_base + VEC_OFS[win_idx];                        // [RULE8] [RULE14]
        last_num_q <= win_idx + FIRST_IRQ_VEC_NUM;
      end
    end
  end

  // ****************************************************************
  // Event status, mask and interrupt line
  // ****************************************************************
  always_comb
  begin
    evt                     = '0;
    evt[EVT_TABLE_MOVED]    = select_write;
    evt[EVT_UNLOCK_EXPIRED] = expired;
    evt[EVT_VECTOR_TAKEN]   = take;
  end

  // New events beat the clear-on-read in the same cycle
  assign stat_d = ((reg_re_in && hit(reg_addr_in, REG_INT_STAT)) ? '0 : stat_q) | evt;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      stat_q <= '0;
    else
      stat_q <= stat_d;
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      mask_q <= '0;
    else if (reg_we_in && hit(reg_addr_in, REG_INT_MASK))
      mask_q <= reg_wdata_in[EVT_W-1:0];
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      irq_q <= 1'b0;
    else
      irq_q <= |(stat_d & mask_q);
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      rdata_q <= '0;
    else if (!reg_re_in)
      rdata_q <= '0;
    else if (hit(reg_addr_in, REG_MCU_CTRL))
      rdata_q <= DW'({select_q, unlock});
    else if (hit(reg_addr_in, REG_INT_STAT))
      rdata_q <= DW'(stat_q);
    else if (hit(reg_addr_in, REG_INT_MASK))
      rdata_q <= DW'(mask_q);
    else if (hit(reg_addr_in, REG_VEC_STAT))
    begin
      rdata_q                                 <= '0;
      rdata_q[VSTAT_NUM_LSB +: IDX_W]         <= last_num_q;
      rdata_q[VSTAT_FUSE_BIT]                 <= fuse_q;
      rdata_q[VSTAT_BLOCK_BIT]                <= block;
    end
    else
      rdata_q <= '0;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_reset_app;
    @(posedge clock_in) disable iff (!rst_n_in)
    fuse_cap_q && fuse_q |=> reset_vector_out == 16'h0000;
  endproperty
  a_reset_app: assert property (p_reset_app) // [RULE1]
    else $error("reset vector not zero with fuse unprogrammed");

  property p_reset_boot;
    @(posedge clock_in) disable iff (!rst_n_in)
    fuse_cap_q && !fuse_q |=> reset_vector_out == 16'h1C00;
  endproperty
  a_reset_boot: assert property (p_reset_boot) // [RULE7]
    else $error("reset vector not boot address with fuse programmed");

  property p_reset_indep;
    @(posedge clock_in) disable iff (!rst_n_in)
    fuse_cap_q ##1 $changed(select_q) |-> $stable(reset_vector_out);
  endproperty
  a_reset_indep: assert property (p_reset_indep) // [RULE9]
    else $error("reset vector moved with select bit");

  property p_external_irq_zero_addr;
    @(posedge clock_in) disable iff (!rst_n_in)
    take && win_idx == 5'h00 |=>
      vector_addr_out == ($past(select_q) ? 16'h1C02 : 16'h0002);
  endproperty
  a_external_irq_zero_addr: assert property (p_external_irq_zero_addr) // [RULE2]
    else $error("external request zero vector misplaced");

  property p_serial_addr;
    @(posedge clock_in) disable iff (!rst_n_in)
    take && win_idx == 5'h0B && !select_q |=> vector_addr_out == 16'h0018;
  endproperty
  a_serial_addr: assert property (p_serial_addr) // [RULE5]
    else $error("serial transfer vector misplaced");

  property p_boot_span;
    @(posedge clock_in) disable iff (!rst_n_in)
    take && select_q |=> vector_addr_out >= 16'h1C02 && vector_addr_out <= 16'h1C2C;
  endproperty
  a_boot_span: assert property (p_boot_span) // [RULE11]
    else $error("relocated vector outside boot table");

  property p_fetch_only_taken;
    @(posedge clock_in) disable iff (!rst_n_in)
    !take |=> !vector_valid_out;
  endproperty
  a_fetch_only_taken: assert property (p_fetch_only_taken) // [RULE10]
    else $error("vector presented without accepted interrupt");

  property p_unlock_expire;
    @(posedge clock_in) disable iff (!rst_n_in)
    set_unlock ##1 (!set_unlock)[*4] |=> !unlock;
  endproperty
  a_unlock_expire: assert property (p_unlock_expire) // [RULE12]
    else $error("unlock held past four cycles");

  property p_block;
    @(posedge clock_in) disable iff (!rst_n_in)
    set_unlock |-> !take ##1 !irq_pending_out;
  endproperty
  a_block: assert property (p_block) // [RULE13]
    else $error("interrupt accepted during unlock");

  property p_lowest;
    @(posedge clock_in) disable iff (!rst_n_in)
    take |-> (irq_req_in & NUM_IRQ'((22'h1 << win_idx) - 22'h1)) == '0;
  endproperty
  a_lowest: assert property (p_lowest) // [RULE14]
    else $error("higher vector chosen over lower pending one");

  property p_stride;
    @(posedge clock_in) disable iff (!rst_n_in)
    take |=> vector_addr_out ==
      $past(table_base) + VEC_STRIDE + AW'({$past(win_idx), 1'b0});
  endproperty
  a_stride: assert property (p_stride) // [RULE15] [RULE8]
    else $error("vector spacing not two words");

  c_relocated_take: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    take && select_q);
  c_select_moved: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    set_unlock ##[1:4] select_write);
  c_unlock_expired: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    expired);

endmodule

`default_nettype wire

// *** tb_top.sv ***
// Purpose: Self-checking bench for the vector placement block
// Assumes: Core model supplies accept, instruction done and global enable
// Notes:   Registers reached through one-cycle strobes with a gap after each
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import rivp_pkg::*;

  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic        fuse = 1'b1;
  logic [20:0] irq_req = 21'h0;
  logic        ie_cmd = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] reg_rdata;
  logic        global_ie, accept, instr_done, pending, vvalid, vsel, irq;
  logic [15:0] reset_vec, vaddr, fetch_addr;
  logic [7:0]  fetch_count;
  int          fail_count = 0;
  int          num_checks = 0;

  always #25 clock = ~clock;

  rivp_vector_ctrl u_rivp_vector_ctrl (
    .clock_in(clock), .rst_n_in(rst_n), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_we_in(reg_we), .reg_re_in(reg_re),
    .reg_rdata_out(reg_rdata), .boot_reset_select_fuse_in(fuse),
    .irq_req_in(irq_req), .global_ie_in(global_ie), .core_accept_in(accept),
    .instr_done_in(instr_done), .reset_vector_out(reset_vec),
    .irq_pending_out(pending), .vector_addr_out(vaddr),
    .vector_valid_out(vvalid), .vector_table_select_out(vsel), .irq_out(irq)
  );

  rivp_core_model u_rivp_core_model (
    .clock_in(clock), .rst_n_in(rst_n), .irq_pending_in(pending),
    .vector_valid_in(vvalid), .vector_addr_in(vaddr), .ie_cmd_in(ie_cmd),
    .slow_in(slow), .core_accept_out(accept), .instr_done_out(instr_done),
    .global_ie_out(global_ie), .fetch_addr_out(fetch_addr),
    .fetch_count_out(fetch_count)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic do_reset(input logic f);
    rst_n <= 1'b0;
    fuse  <= f;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask

  // Idle cycle after each strobe keeps two drivers off one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_we <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge clock);
  endtask

  task automatic take(input logic [20:0] m, input logic [15:0] exp);
    logic [7:0] c0;
    int         n;
    c0 = fetch_count;
    n = 0;
    irq_req <= m;
    while (fetch_count === c0 && n < 40)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 40)
    begin
      fail_count++;
      $display("ERROR vector fetch timeout expected %0h seen %0h", exp, fetch_addr);
    end
    chk("vector address", {16'h0, exp}, {16'h0, fetch_addr});
    irq_req <= 21'h0;
    repeat (12) @(posedge clock);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_table();
    for (int i = 0; i < NUM_IRQ; i++)
    begin
      take(21'h1 << i, 16'(2 * (i + 1)));
    end
  endtask

  task automatic t_prio();
    slow <= 1'b1;
    take(21'h1A0010, 16'h000A);
    take(21'h1FFFFF, 16'h0002);
    slow <= 1'b0;
  endtask

  task automatic t_noie();
    logic [7:0] c0;
    ie_cmd <= 1'b0;
    repeat (3) @(posedge clock);
    c0 = fetch_count;
    irq_req <= 21'h1;
    repeat (10) @(posedge clock);
    chk("take count", {24'h0, c0}, {24'h0, fetch_count});
    irq_req <= 21'h0;
    ie_cmd  <= 1'b1;
    repeat (3) @(posedge clock);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    wr(REG_INT_MASK, 32'h0);
    rd(REG_INT_STAT, d);
    take(21'h000002, 16'h0004);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(REG_VEC_STAT, d);
    chk("vector status", 32'h103, d);
    wr(REG_INT_MASK, 32'h4);
    repeat (2) @(posedge clock);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    rd(REG_INT_STAT, d);
    chk("status taken", 32'h4, d & 32'h4);
    repeat (2) @(posedge clock);
    chk("irq after clear", 32'h0, {31'h0, irq});
    rd(8'h40, d);
    chk("unmapped read", 32'h0, d);
  endtask

  task automatic t_move();
    logic [31:0] d;
    wr(REG_MCU_CTRL, 32'h1);
    wr(REG_MCU_CTRL, 32'h2);
    chk("table select", 32'h1, {31'h0, vsel});
    rd(REG_MCU_CTRL, d);
    chk("unlock after select", 32'h0, d & 32'h1);
    rd(REG_INT_STAT, d);
    chk("status moved", 32'h1, d & 32'h1);
    take(21'h000001, 16'h1C02);
    take(21'h100000, 16'h1C2A);
    chk("reset vector moved", 32'h0, {16'h0, reset_vec});
  endtask

  task automatic t_lock();
    logic [31:0] d;
    logic [7:0]  c0;
    int          n;
    ie_cmd  <= 1'b0;
    irq_req <= 21'h1;
    repeat (3) @(posedge clock);
    c0 = fetch_count;
    wr(REG_MCU_CTRL, 32'h1);
    ie_cmd <= 1'b1;
    repeat (3)
    begin
      @(posedge clock);
      #1;
      chk("pending while unlocked", 32'h0, {31'h0, pending});
    end
    rd(REG_MCU_CTRL, d);
    chk("unlock expired", 32'h0, d & 32'h1);
    rd(REG_INT_STAT, d);
    chk("status expired", 32'h2, d & 32'h2);
    n = 0;
    while (fetch_count === c0 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 20)
    begin
      fail_count++;
      $display("ERROR take after window timeout expected %0h seen %0h", 16'h1C02, fetch_addr);
    end
    chk("take after window", 32'h1C02, {16'h0, fetch_addr});
    irq_req <= 21'h0;
    repeat (12) @(posedge clock);
    wr(REG_MCU_CTRL, 32'h0);
    repeat (2) @(posedge clock);
    chk("late select write", 32'h1, {31'h0, vsel});
  endtask

  // ****************************************************************
  // Sequence and watchdog
  // ****************************************************************
  initial
  begin
    do_reset(1'b1);
    chk("reset vector", 32'h0, {16'h0, reset_vec});
    ie_cmd <= 1'b1;
    t_table();
    t_prio();
    t_noie();
    t_regs();
    t_move();
    t_lock();
    do_reset(1'b0);
    chk("boot reset vector", 32'h1C00, {16'h0, reset_vec});
    chk("select after reset", 32'h0, {31'h0, vsel});
    take(21'h000001, 16'h0002);
    conclude();
  end

  // Whole sequence needs about 600 cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    fail_count++;
    conclude();
  end
endmodule

`default_nettype wire
